// ### design/alu_pkg.sv
/*
  Shared constants for the sliced ALU datapath: widths, control encodings,
  flag positions, register-bus offsets and context-switch timing.
  Assumes a 100 MHz core clock.
*/
package alu_pkg;
  localparam int DATA_W = 16;
  localparam int SLICE_W = 4;
  localparam int NUM_SLICES = DATA_W / SLICE_W;
  localparam int BLOCK_REGS = 16;
  localparam int WORK_REGS = 8;
  localparam int LEVELS = 16;
  localparam int MICRO_REGS = 9;
  localparam logic [3:0] REG_ACC = 4'h5;
  localparam logic [3:0] REG_SCRATCH0 = 4'h8;
  // Operand sources of the R and S selectors
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_BUS = 2'h2;
  localparam logic [1:0] SRC_HOLD = 2'h3;
  // Result destinations
  localparam logic [1:0] DST_NONE = 2'h0;
  localparam logic [1:0] DST_HOLD = 2'h1;
  localparam logic [1:0] DST_BUS = 2'h2;
  localparam logic [1:0] DST_BLOCK = 2'h3;
  // Shift linkage control
  localparam logic [1:0] SH_NONE = 2'h0;
  localparam logic [1:0] SH_LEFT = 2'h1;
  localparam logic [1:0] SH_RIGHT = 2'h2;
  typedef enum logic [2:0] {
    FN_PASS_R = 3'h0, FN_ADD = 3'h1, FN_SUB = 3'h2, FN_AND = 3'h3,
    FN_OR = 3'h4, FN_XOR = 3'h5, FN_PASS_S = 3'h6, FN_NOT_R = 3'h7
  } alu_fn_e;
  // Status flag positions
  localparam int FLAGS_W = 5;
  localparam int FLAG_C = 0;
  localparam int FLAG_O = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_M = 3;
  localparam int FLAG_LINK = 4;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  // Register bus, byte offsets
  localparam int AV_ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_ACC = 4'h8;
  localparam logic [3:0] OFF_PREV = 4'hC;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_LVL_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LVL_LSB = 4;
  localparam int STAT_FLAG_LSB = 8;
  // Context switch budget
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_TIME_NS = 5000;
  localparam int SWITCH_CYCLES = SWITCH_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SW_IDLE = 2'h0, SW_SAVE = 2'h1, SW_SWAP = 2'h3, SW_LOAD = 2'h2
  } sw_state_e;
endpackage : alu_pkg

// ### design/alu_slice.sv
/*
  One 4-bit ALU slice with carry in and out; the top slice's internal carry
  gives overflow. Assumes the function code is stable for the whole cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module alu_slice #(
  parameter int W = 4
) (
  input wire logic [W-1:0] rIn, // R operand nibble
  input wire logic [W-1:0] sIn, // S operand nibble
  input wire alu_pkg::alu_fn_e fn, // Function select
  input wire logic carryIn, // Carry from lower slice
  output logic [W-1:0] fOut, // Result nibble
  output logic carryOut, // Carry to upper slice
  output logic carryMsb // Carry into the top bit
);
  import alu_pkg::*;
  logic [W-1:0] sx;
  logic [W:0] sum;
  logic [W-1:0] lowSum;

  // Subtraction reuses the adder with an inverted S and a forced carry
  always_comb begin
    sx = (fn == FN_SUB) ? ~sIn : sIn;
    sum = {1'b0, rIn} + {1'b0, sx} + {{W{1'b0}}, carryIn};
    lowSum = {1'b0, rIn[W-2:0]} + {1'b0, sx[W-2:0]} + {{(W-1){1'b0}}, carryIn};
    carryOut = 1'b0;
    carryMsb = 1'b0;
    case (fn)
      FN_PASS_R: fOut = rIn;
      FN_ADD, FN_SUB: begin
        fOut = sum[W-1:0];
        carryOut = sum[W];
        carryMsb = lowSum[W-1];
      end
      FN_AND: fOut = rIn & sIn;
      FN_OR: fOut = rIn | sIn;
      FN_XOR: fOut = rIn ^ sIn;
      FN_PASS_S: fOut = sIn;
      FN_NOT_R: fOut = ~rIn;
      default: fOut = rIn;
    endcase
  end
endmodule : alu_slice
`default_nettype wire

// ### design/level_file.sv
/*
  Register file with one working set per program level plus the
  microprogram-only registers. One combinational read, one clocked write.
  Assumes the caller gates the write enable with the clock enable.
*/
`timescale 1ns/1ns
`default_nettype none
module level_file #(
  parameter int LEVELS = 16,
  parameter int WORK_REGS = 8,
  parameter int MICRO_REGS = 9,
  parameter int DATA_W = 16
) (
  input wire logic core_clk, // Core clock
  input wire logic [3:0] rdLevel, // Read level
  input wire logic [3:0] rdReg, // Read register
  input wire logic rdMicro, // Read from micro-only bank
  output logic [DATA_W-1:0] rdData, // Read data
  input wire logic wrEn, // Write strobe
  input wire logic [3:0] wrLevel, // Write level
  input wire logic [3:0] wrReg, // Write register
  input wire logic wrMicro, // Write to micro-only bank
  input wire logic [DATA_W-1:0] wrData // Write data
);
  localparam int DEPTH = LEVELS * WORK_REGS + MICRO_REGS;
  logic [DATA_W-1:0] mem [DEPTH];

  // Flat index; out-of-range micro numbers fold onto the last register
  function automatic int fileIndex(input logic [3:0] lvl, input logic [3:0] rn,
                                   input logic micro);
    int idx;
    if (micro) begin
      idx = LEVELS * WORK_REGS + ((int'(rn) < MICRO_REGS) ? int'(rn) : MICRO_REGS - 1);
    end else begin
      idx = int'(lvl) * WORK_REGS + int'(rn[2:0]);
    end
    return idx;
  endfunction : fileIndex

  assign rdData = mem[fileIndex(rdLevel, rdReg, rdMicro)];

  // Contents are data only; no reset so the array maps to plain memory
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[fileIndex(wrLevel, wrReg, wrMicro)] <= wrData;
    end
  end
endmodule : level_file
`default_nettype wire

// ### design/slice_datapath.sv
/*
  Sixteen-bit sliced ALU datapath: current register block, R/S selectors,
  holding register, shift linkage, status flags, per-level register file and
  a hardware context-switch sequencer started over an Avalon-MM slave.
  Assumes the microinstruction inputs come from a pipeline register on
  core_clk and stay stable for the whole microcycle.
*/
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module slice_datapath (
  input wire logic core_clk, // Microcycle clock
  input wire logic reset_n, // Async reset, active low
  input wire logic clkEn, // Freezes all state when low
  input wire logic [alu_pkg::AV_ADDR_W-1:0] avsAddress, // Byte address
  input wire logic avsRead, // Read request
  input wire logic avsWrite, // Write request
  input wire logic [31:0] avsWriteData, // Write data
  output logic [31:0] avsReadData, // Read data
  output logic avsWaitRequest, // Stall
  input wire logic [3:0] aSel, // First source select
  input wire logic [3:0] bSel, // Second source select and destination
  input wire logic [1:0] rSrc, // R selector
  input wire logic [1:0] sSrc, // S selector
  input wire alu_pkg::alu_fn_e aluFn, // ALU function
  input wire logic [1:0] dest, // Result destination
  input wire logic [1:0] shiftOp, // Shift linkage control
  input wire logic shiftLinked, // Link holding register into shift
  input wire logic rightIn, // Serial in at bit 0
  input wire logic leftIn, // Serial in at bit 15
  output logic leftOut, // Serial out, left shifts
  output logic rightOut, // Serial out, right shifts
  input wire logic rfRead, // File register drives shared bus
  input wire logic rfWrite, // Result written into file
  input wire logic rfMicro, // Select micro-only bank
  input wire logic [3:0] rfLevel, // File level select
  input wire logic [3:0] rfReg, // File register select
  input wire logic [15:0] sharedBusIn, // internal_shared_bus level in
  output logic [15:0] sharedBusOut, // internal_shared_bus drive value
  output logic sharedBusOe, // High while driving the bus
  output logic [alu_pkg::FLAGS_W-1:0] statusFlags, // Condition flags
  output logic [3:0] curLevel, // Running program level
  output logic switchBusy // Context switch in progress
);
  import alu_pkg::*;

  logic [DATA_W-1:0] blockFf [BLOCK_REGS];
  logic [DATA_W-1:0] holdFf, nxt_hold;
  logic [FLAGS_W-1:0] flagsFf, nxt_flags;
  logic [DATA_W-1:0] busOutFf, nxt_busOut;
  logic busOeFf, nxt_busOe;
  logic leftOutFf, nxt_leftOut, rightOutFf, nxt_rightOut;
  sw_state_e swFf, nxt_sw;
  logic [2:0] idxFf, nxt_idx;
  logic [3:0] levelFf, nxt_level, tgtFf, nxt_tgt, prevFf, nxt_prev;
  logic ackFf, nxt_ack;
  logic [31:0] rdDataFf, nxt_rdData;
  logic exec, saving, loading, startSwitch;
  logic [DATA_W-1:0] busVal, rOp, sOp, aluRes, finalRes, fileRd;
  alu_fn_e effFn;
  logic [NUM_SLICES:0] carry;
  logic [NUM_SLICES-1:0] carryMsb;
  logic shOut, blkWr, fileWrEn;
  logic [3:0] blkWrIdx, fileWrLevel, fileWrReg, fileRdLevel, fileRdReg;
  logic [DATA_W-1:0] blkWrData, fileWrData;

  // Operand selector shared by R and S
  function automatic logic [DATA_W-1:0] pickOperand(input logic [1:0] src,
      input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
      input logic [DATA_W-1:0] bus, input logic [DATA_W-1:0] hold);
    case (src)
      SRC_A: return a;
      SRC_B: return b;
      SRC_BUS: return bus;
      default: return hold;
    endcase
  endfunction : pickOperand

  assign exec = clkEn && (swFf == SW_IDLE); // Microinstructions wait during a switch
  assign saving = (swFf == SW_SAVE);
  assign loading = (swFf == SW_LOAD);

  // Shared bus source: a file register when asked for, otherwise the pins
  assign busVal = (rfRead || loading) ? fileRd : sharedBusIn;
  // Loading forces a pass of the bus value, the same path the microcode uses
  always_comb begin
    rOp = loading ? busVal : pickOperand(rSrc, blockFf[aSel], blockFf[bSel], busVal,
                                         holdFf);
    sOp = pickOperand(sSrc, blockFf[aSel], blockFf[bSel], busVal, holdFf);
    effFn = loading ? FN_PASS_R : aluFn;
  end

  // Carry chain across the slices
  assign carry[0] = (effFn == FN_SUB);
  generate
    for (genvar g = 0; g < NUM_SLICES; g++) begin : g_slice
      alu_slice #(.W(SLICE_W)) u_slice (
        .rIn(rOp[g*SLICE_W +: SLICE_W]),
        .sIn(sOp[g*SLICE_W +: SLICE_W]),
        .fn(effFn),
        .carryIn(carry[g]),
        .fOut(aluRes[g*SLICE_W +: SLICE_W]),
        .carryOut(carry[g+1]),
        .carryMsb(carryMsb[g])
      );
    end
  endgenerate

  // Shift linkage: serial ends and the optional 32-bit pairing with hold
  always_comb begin
    finalRes = aluRes;
    nxt_hold = holdFf;
    shOut = 1'b0;
    case (shiftOp)
      SH_LEFT: begin
        shOut = aluRes[DATA_W-1];
        if (shiftLinked) begin
          finalRes = {aluRes[DATA_W-2:0], holdFf[DATA_W-1]};
          nxt_hold = {holdFf[DATA_W-2:0], rightIn};
        end else begin
          finalRes = {aluRes[DATA_W-2:0], rightIn};
        end
      end
      SH_RIGHT: begin
        finalRes = {leftIn, aluRes[DATA_W-1:1]};
        if (shiftLinked) begin
          nxt_hold = {aluRes[0], holdFf[DATA_W-1:1]};
          shOut = holdFf[0];
        end else begin
          shOut = aluRes[0];
        end
      end
      default: ;
    endcase
    if (loading || !exec) begin
      nxt_hold = holdFf;
    end else if (dest == DST_HOLD && !(shiftOp != SH_NONE && shiftLinked)) begin
      nxt_hold = finalRes;
    end
  end

  // Flags, serial outputs and bus drive follow each executed microcycle
  always_comb begin
    nxt_flags = flagsFf;
    nxt_leftOut = leftOutFf;
    nxt_rightOut = rightOutFf;
    nxt_busOut = busOutFf;
    nxt_busOe = 1'b0;
    if (exec) begin
      nxt_flags[FLAG_C] = carry[NUM_SLICES];
      nxt_flags[FLAG_O] = carry[NUM_SLICES] ^ carryMsb[NUM_SLICES-1];
      nxt_flags[FLAG_Z] = (finalRes == '0);
      nxt_flags[FLAG_M] = finalRes[DATA_W-1];
      nxt_flags[FLAG_LINK] = shOut;
      nxt_leftOut = (shiftOp == SH_LEFT) ? shOut : 1'b0;
      nxt_rightOut = (shiftOp == SH_RIGHT) ? shOut : 1'b0;
      if (dest == DST_BUS) begin
        nxt_busOut = finalRes;
        nxt_busOe = 1'b1;
      end
    end
  end

  // One block register written per microcycle; the second select names it, or the switch index while loading
  always_comb begin
    blkWr = 1'b0;
    blkWrIdx = bSel;
    blkWrData = finalRes;
    if (loading) begin
      blkWr = clkEn;
      blkWrIdx = {1'b0, idxFf};
    end else if (exec && dest == DST_BLOCK) begin
      blkWr = 1'b1;
    end
  end

  // File ports: the sequencer owns them during a switch
  always_comb begin
    fileRdLevel = loading ? levelFf : rfLevel;
    fileRdReg = loading ? {1'b0, idxFf} : rfReg;
    fileWrEn = saving ? clkEn : (exec && rfWrite);
    fileWrLevel = saving ? levelFf : rfLevel;
    fileWrReg = saving ? {1'b0, idxFf} : rfReg;
    fileWrData = saving ? blockFf[idxFf] : finalRes;
  end

  level_file #(.LEVELS(LEVELS), .WORK_REGS(WORK_REGS), .MICRO_REGS(MICRO_REGS),
               .DATA_W(DATA_W)) u_file (
    .core_clk(core_clk),
    .rdLevel(fileRdLevel),
    .rdReg(fileRdReg),
    .rdMicro(rfMicro && !loading),
    .rdData(fileRd),
    .wrEn(fileWrEn),
    .wrLevel(fileWrLevel),
    .wrReg(fileWrReg),
    .wrMicro(rfMicro && !saving),
    .wrData(fileWrData)
  );

  // Context switch: save eight, swap level, load eight; well inside budget
  always_comb begin
    nxt_sw = swFf;
    nxt_idx = idxFf;
    nxt_level = levelFf;
    nxt_prev = prevFf;
    nxt_tgt = tgtFf;
    case (swFf)
      SW_IDLE: begin
        if (startSwitch) begin
          nxt_tgt = avsWriteData[CTRL_LVL_LSB +: 4];
          nxt_sw = SW_SAVE;
          nxt_idx = 3'h0;
        end
      end
      SW_SAVE: begin
        nxt_idx = idxFf + 3'h1;
        if (idxFf == 3'h7) nxt_sw = SW_SWAP;
      end
      SW_SWAP: begin
        nxt_prev = levelFf;
        nxt_level = tgtFf;
        nxt_sw = SW_LOAD;
      end
      SW_LOAD: begin
        nxt_idx = idxFf + 3'h1;
        if (idxFf == 3'h7) nxt_sw = SW_IDLE;
      end
      default: nxt_sw = SW_IDLE;
    endcase
  end

  // Avalon slave: one wait cycle, then the answer at the releasing edge
  assign avsWaitRequest = (avsRead || avsWrite) && !ackFf;
  assign startSwitch = avsWrite && ackFf && (avsAddress == OFF_CTRL)
                       && avsWriteData[CTRL_GO_BIT]; // A start while busy is dropped
  always_comb begin
    nxt_ack = (avsRead || avsWrite) && !ackFf;
    nxt_rdData = rdDataFf;
    if (avsRead && !ackFf) begin
      nxt_rdData = 32'h0000_0000;
      case (avsAddress)
        OFF_CTRL: nxt_rdData[CTRL_LVL_LSB +: 4] = tgtFf;
        OFF_STATUS: begin
          nxt_rdData[STAT_BUSY_BIT] = (swFf != SW_IDLE);
          nxt_rdData[STAT_LVL_LSB +: 4] = levelFf;
          nxt_rdData[STAT_FLAG_LSB +: FLAGS_W] = flagsFf;
        end
        OFF_ACC: nxt_rdData[DATA_W-1:0] = blockFf[REG_ACC];
        OFF_PREV: nxt_rdData[3:0] = prevFf;
        default: ;
      endcase
    end
  end

  // All state moves on the pipeline-load edge, frozen while clkEn is low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < BLOCK_REGS; i++) blockFf[i] <= '0;
      holdFf <= '0;
      flagsFf <= FLAGS_RST;
      busOutFf <= '0;
      busOeFf <= 1'b0;
      leftOutFf <= 1'b0;
      rightOutFf <= 1'b0;
      swFf <= SW_IDLE;
      idxFf <= 3'h0;
      levelFf <= 4'h0;
      tgtFf <= 4'h0;
      prevFf <= 4'h0;
      ackFf <= 1'b0;
      rdDataFf <= 32'h0000_0000;
    end else if (clkEn) begin
      if (blkWr) blockFf[blkWrIdx] <= blkWrData;
      holdFf <= nxt_hold;
      flagsFf <= nxt_flags;
      busOutFf <= nxt_busOut;
      busOeFf <= nxt_busOe;
      leftOutFf <= nxt_leftOut;
      rightOutFf <= nxt_rightOut;
      swFf <= nxt_sw;
      idxFf <= nxt_idx;
      levelFf <= nxt_level;
      tgtFf <= nxt_tgt;
      prevFf <= nxt_prev;
      ackFf <= nxt_ack;
      rdDataFf <= nxt_rdData;
    end
  end

  assign avsReadData = rdDataFf;
  assign sharedBusOut = busOutFf;
  assign sharedBusOe = busOeFf;
  assign leftOut = leftOutFf;
  assign rightOut = rightOutFf;
  assign statusFlags = flagsFf;
  assign curLevel = levelFf;
  assign switchBusy = (swFf != SW_IDLE);

  // Switch length counter, read only by the checks below
  logic [9:0] busyCnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) busyCnt <= 10'h000;
    else if (clkEn && swFf == SW_IDLE) busyCnt <= 10'h000;
    else if (clkEn && busyCnt != 10'h3FF) busyCnt <= busyCnt + 10'h001;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_block_dest: assert property (
    exec && dest == DST_BLOCK |=> blockFf[$past(bSel)] == $past(finalRes))
    else $error("block write missed its destination");
  chk_hold_load: assert property (
    exec && dest == DST_HOLD && shiftOp == SH_NONE |=> holdFf == $past(finalRes))
    else $error("holding register not loaded");
  chk_bus_drive: assert property (
    exec && dest == DST_BUS |=> sharedBusOe && sharedBusOut == $past(finalRes))
    else $error("result not driven on the shared bus");
  chk_pass_r: assert property (
    effFn == FN_PASS_R |-> aluRes == rOp)
    else $error("pass function altered R");
  chk_add_rs: assert property (
    effFn == FN_ADD |-> {carry[NUM_SLICES], aluRes} == {1'b0, rOp} + {1'b0, sOp})
    else $error("R plus S wrong");
  chk_zero_flag: assert property (
    exec |=> flagsFf[FLAG_Z] == ($past(finalRes) == '0))
    else $error("zero flag not updated");
  chk_linked_left: assert property (
    exec && shiftLinked && shiftOp == SH_LEFT
    |=> holdFf == {$past(holdFf[DATA_W-2:0]), $past(rightIn)})
    else $error("linked left shift lost a bit");
  chk_switch_bound: assert property (
    busyCnt <= 10'(SWITCH_CYCLES))
    else $error("context switch overran its budget");
  chk_save_level: assert property (
    saving && clkEn |-> fileWrEn && fileWrLevel == levelFf && fileWrData == blockFf[idxFf])
    else $error("save wrote the wrong slot");
  chk_scratch_kept: assert property (
    swFf != SW_IDLE |=> $stable(blockFf[REG_SCRATCH0]))
    else $error("scratch register changed in a switch");

  cov_switch_done: cover property (swFf == SW_LOAD && nxt_sw == SW_IDLE && clkEn);
  cov_add_to_acc: cover property (exec && aluFn == FN_ADD && dest == DST_BLOCK
                                  && bSel == REG_ACC);
  cov_linked_right: cover property (exec && shiftLinked && shiftOp == SH_RIGHT);
endmodule : slice_datapath
`default_nettype wire

// ### verification/micro_pipeline_model.sv
/*
  Behavioural microprogram pipeline register plus the read buffer that
  drives the shared bus. Assumes the bench presents the next word before
  each rising edge of core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module micro_pipeline_model (
  input wire logic core_clk, // Microcycle clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [30:0] nxtWord, // Next microinstruction
  input wire logic busDrive, // Buffer enables onto the bus
  input wire logic [15:0] busData, // Buffer contents
  output logic [30:0] pipeWord, // Executing microinstruction
  output logic [15:0] sharedBus // Bus level seen by the datapath
);
  logic [30:0] word_ff;
  logic drive_ff;
  logic [15:0] data_ff;
  // Whole word loads on one edge and stands for the full microcycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_ff <= 31'h0;
      drive_ff <= 1'h0;
      data_ff <= 16'h0;
    end else begin
      word_ff <= nxtWord;
      drive_ff <= busDrive;
      if (busDrive) begin
        data_ff <= busData;
      end
    end
  end
  assign pipeWord = word_ff;
  // Released bus shows the inverse of its last value, so stale data never matches
  assign sharedBus = drive_ff ? data_ff : ~data_ff;
endmodule : micro_pipeline_model
`default_nettype wire

// ### verification/test_bit_slice_alu_with_level_register_file.sv
/*
  Self-checking bench for the sliced ALU datapath: microinstructions go
  through the pipeline model, registers are read over Avalon-MM.
  Assumes alu_pkg and the design modules are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_bit_slice_alu_with_level_register_file;
  import alu_pkg::*;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'h0;
  logic avsWrite = 1'h0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData, rd;
  logic avsWaitRequest, leftOut, rightOut, sharedBusOe, switchBusy;
  logic [30:0] nxtWord = 31'h0;
  logic [30:0] pw;
  logic busDrive = 1'h0;
  logic clkEn = 1'h1;
  logic [15:0] busData = 16'h0;
  logic [15:0] sharedBusIn, sharedBusOut;
  logic [4:0] statusFlags;
  logic [3:0] curLevel;
  int n_fail = 0;
  int checked = 0;
  // Free-running 100 MHz clock
  always #5 core_clk = ~core_clk;
  micro_pipeline_model i_micro_pipeline_model (.core_clk(core_clk), .reset_n(reset_n),
    .nxtWord(nxtWord), .busDrive(busDrive), .busData(busData), .pipeWord(pw),
    .sharedBus(sharedBusIn));
  // Serial ends tied low so the shifted-in bits are known
  slice_datapath i_slice_datapath (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .aSel(pw[30:27]), .bSel(pw[26:23]), .rSrc(pw[22:21]), .sSrc(pw[20:19]),
    .aluFn(alu_fn_e'(pw[18:16])), .dest(pw[15:14]), .shiftOp(pw[13:12]),
    .shiftLinked(pw[11]), .rightIn(1'h0), .leftIn(1'h0), .leftOut(leftOut),
    .rightOut(rightOut), .rfRead(pw[10]), .rfWrite(pw[9]), .rfMicro(pw[8]),
    .rfLevel(pw[7:4]), .rfReg(pw[3:0]), .sharedBusIn(sharedBusIn),
    .sharedBusOut(sharedBusOut), .sharedBusOe(sharedBusOe), .statusFlags(statusFlags),
    .curLevel(curLevel), .switchBusy(switchBusy));
  // Closing report, the only place the run ends
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // One bus access; request held until waitrequest is sampled low at a rising edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitRequest !== 1'h0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      wrap_up();
    end
    rd = avsReadData;
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
  endtask : av
  // One microinstruction: pipeline loads it, datapath executes on the next edge
  task automatic uop(input logic [3:0] aS, bS, input logic [1:0] rS, sS,
      input logic [2:0] fn, input logic [1:0] dst, input logic [15:0] ext,
      input logic [13:0] more);
    @(posedge core_clk);
    nxtWord <= {aS, bS, rS, sS, fn, dst, more};
    busDrive <= (rS == SRC_BUS);
    busData <= ext;
    @(posedge core_clk);
    nxtWord <= 31'h0;
    busDrive <= 1'h0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : uop
  // Level change started from software; busy length is bounded
  task automatic swlvl(input logic [3:0] lv);
    int n;
    av(1'h1, OFF_CTRL, {24'h0, lv, 4'h1});
    @(negedge core_clk);
    n = 0;
    while (switchBusy === 1'h1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    `CHK((n > 0) && (n <= SWITCH_CYCLES), 1'h1)
    `CHK(curLevel, lv)
  endtask : swlvl
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'h1;
    av(1'h0, OFF_STATUS, 32'h0);
    // Idle words pass block zero, a zero result, so only the zero flag is up
    `CHK(rd, 32'h0000_0400)
    av(1'h0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    $display("reset and unmapped test done");
    uop(4'h0, REG_ACC, SRC_BUS, SRC_A, FN_PASS_R, DST_BLOCK, 16'h1234, 14'h0);
    av(1'h0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0000_1234)
    uop(4'h0, 4'h2, SRC_BUS, SRC_A, FN_PASS_R, DST_BLOCK, 16'h8000, 14'h0);
    uop(4'h0, REG_ACC, SRC_BUS, SRC_A, FN_PASS_R, DST_BLOCK, 16'h8000, 14'h0);
    uop(4'h2, REG_ACC, SRC_A, SRC_B, FN_ADD, DST_BLOCK, 16'h0, 14'h0);
    `CHK(statusFlags, 5'h07)
    av(1'h0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0)
    $display("load and add test done");
    uop(4'h0, REG_SCRATCH0, SRC_BUS, SRC_A, FN_PASS_R, DST_BLOCK, 16'hBEEF, 14'h0);
    uop(4'h0, REG_ACC, SRC_BUS, SRC_A, FN_PASS_R, DST_BLOCK, 16'h00A5, 14'h0);
    uop(REG_SCRATCH0, 4'h0, SRC_A, SRC_A, FN_PASS_R, DST_BUS, 16'h0, 14'h0);
    `CHK({sharedBusOe, sharedBusOut}, 17'h1_BEEF)
    // Known contents for level three, so the switch loads defined values
    for (int i = 0; i < 8; i++) begin
      uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_PASS_R, DST_NONE, 16'h3000 | 16'(i),
          {6'h02, 4'h3, 4'(i)});
    end
    swlvl(4'h3);
    av(1'h0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0000_3005)
    av(1'h0, OFF_PREV, 32'h0);
    `CHK(rd, 32'h0)
    av(1'h0, OFF_STATUS, 32'h0);
    `CHK(rd & 32'h0000_00F1, 32'h0000_0030)
    uop(REG_SCRATCH0, 4'h0, SRC_A, SRC_A, FN_PASS_R, DST_BUS, 16'h0, 14'h0);
    `CHK(sharedBusOut, 16'hBEEF)
    swlvl(4'h0);
    av(1'h0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0000_00A5)
    av(1'h0, OFF_PREV, 32'h0);
    `CHK(rd, 32'h0000_0003)
    uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_PASS_R, DST_BUS, 16'h0, 14'h0405);
    `CHK(sharedBusOut, 16'h00A5)
    $display("level change test done");
    uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_PASS_R, DST_HOLD, 16'h8001, 14'h0);
    uop(REG_ACC, REG_ACC, SRC_A, SRC_A, FN_PASS_R, DST_BLOCK, 16'h0, 14'h1800);
    av(1'h0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0000_014B)
    uop(4'h0, 4'h0, SRC_HOLD, SRC_A, FN_PASS_R, DST_BUS, 16'h0, 14'h0);
    `CHK(sharedBusOut, 16'h0002)
    $display("linked shift test done");
    // Plain shifts: {leftOut, rightOut, flags, bus} with zero serial inputs
    uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_PASS_R, DST_BUS, 16'h8001, 14'h1000);
    `CHK({leftOut, rightOut, statusFlags, sharedBusOut}, 23'h50_0002)
    uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_PASS_R, DST_BUS, 16'h8001, 14'h2000);
    `CHK({leftOut, rightOut, statusFlags, sharedBusOut}, 23'h30_4000)
    // Micro-only register written, then read back through R minus zero
    uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_PASS_R, DST_NONE, 16'h0F0F, 14'h0303);
    uop(4'h0, 4'h0, SRC_BUS, SRC_A, FN_SUB, DST_BUS, 16'h0, 14'h0503);
    `CHK({statusFlags, sharedBusOut}, 21'h01_0F0F)
    // A word presented while clkEn is low must leave the accumulator alone
    @(posedge core_clk);
    clkEn <= 1'h0;
    uop(4'h0, REG_ACC, SRC_BUS, SRC_A, FN_PASS_R, DST_BLOCK, 16'hDEAD, 14'h0);
    @(posedge core_clk);
    clkEn <= 1'h1;
    av(1'h0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0000_014B)
    $display("shift, micro bank and freeze test done");
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
endmodule : test_bit_slice_alu_with_level_register_file
`default_nettype wire
